// ### hw/rail_enable_override.sv
module rail_enable_override
   import rail_ctrl_pkg::*;
#(
   parameter int cycles_per_ms = rail_ctrl_pkg::CYC_PER_MS
)
(
   // Clock and reset.
   input  wire logic                                 clk,
   input  wire logic                                 rstn,
   // Register access from the serial bus front end.
   input  wire rail_ctrl_pkg::reg_req_s              reg_req,
   output logic [7:0]                                reg_rdata,
   output logic                                      reg_rvalid,
   // Control-pin and internal power-good enable requests, asynchronous.
   input  wire logic [rail_ctrl_pkg::NUM_RAILS-1:0]  rail_request,
   // Analogue in-regulation flags per pin group, asynchronous.
   input  wire logic [rail_ctrl_pkg::NUM_PINS-1:0]   group_in_reg,
   // Factory configuration.
   input  wire logic                                 shared_sel_strap,
   input  wire logic                                 term_from_two,
   input  wire logic [rail_ctrl_pkg::NUM_PINS-1:0]   pin_sw_mode,
   input  wire logic [rail_ctrl_pkg::NUM_PINS-1:0]   pin_sw_level,
   // Rail enables and output pins.
   output logic [rail_ctrl_pkg::NUM_RAILS-1:0]       rail_enable,
   output logic                                      output_pin_one,
   output logic                                      output_pin_two,
   output logic                                      output_pin_four
);
   import rail_ctrl_pkg::*;

   localparam int SYNC_W = NUM_RAILS + NUM_PINS;

   logic [7:0]             step_down_ctrl;
   logic [7:0]             good_delays;
   logic [7:0]             rail_disable_controls;
   logic [7:0]             rail_force_on_first;
   logic [7:0]             next_step_down_ctrl;
   logic [7:0]             next_good_delays;
   logic [7:0]             next_disable;
   logic [7:0]             next_force_on;
   logic [7:0]             next_rdata;
   logic                   next_rvalid;

   logic [SYNC_W-1:0]      sync1;
   logic [SYNC_W-1:0]      sync2;
   logic [SYNC_W-1:0]      sync3;
   logic [SYNC_W-1:0]      stable;
   logic [SYNC_W-1:0]      next_stable;

   logic                   shared_sel;
   logic                   strap_caught;
   logic                   next_shared_sel;
   logic                   next_strap_caught;

   logic [NUM_RAILS-1:0]   req;
   logic [NUM_RAILS-1:0]   force_vec;
   logic [NUM_RAILS-1:0]   allow;
   logic [NUM_RAILS-1:0]   next_rail_enable;
   logic [NUM_PINS-1:0]    good;
   logic [NUM_PINS-1:0]    done;
   logic [NUM_PINS-1:0]    next_pins;
   logic [NUM_PINS-1:0]    pins;
   logic [2:0]             code [NUM_PINS];
   logic [CNT_W-1:0]       target [NUM_PINS];

   ////////////////////////////////////////////////////////////////////////////
   // Register file. Each access is one byte; a write lands on the next edge
   // and the rails follow one edge later. Unmapped reads return zero.
   always_comb
   begin
      next_step_down_ctrl = step_down_ctrl;
      next_good_delays    = good_delays;
      next_disable        = rail_disable_controls;
      next_force_on       = rail_force_on_first;
      next_rdata          = reg_rdata;
      next_rvalid         = 1'b0;
      if (reg_req.wr)
      begin
         case (reg_req.addr)
            ADDR_STEP_DOWN_CTRL: next_step_down_ctrl = reg_req.wdata & STEP_DOWN_CTRL_MASK;
            ADDR_GOOD_DELAYS:    next_good_delays    = reg_req.wdata;
            ADDR_DISABLE:        next_disable        = reg_req.wdata;
            ADDR_FORCE_ON:       next_force_on       = reg_req.wdata;
            default:             next_rvalid         = 1'b0;
         endcase
      end
      else if (reg_req.rd)
      begin
         next_rvalid = 1'b1;
         case (reg_req.addr)
            ADDR_STEP_DOWN_CTRL: next_rdata = step_down_ctrl;
            ADDR_GOOD_DELAYS:    next_rdata = good_delays;
            ADDR_DISABLE:        next_rdata = rail_disable_controls;
            ADDR_FORCE_ON:       next_rdata = rail_force_on_first;
            default:             next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         step_down_ctrl        <= RST_STEP_DOWN_CTRL;
         good_delays           <= RST_GOOD_DELAYS;
         rail_disable_controls <= RST_DISABLE;
         rail_force_on_first   <= RST_FORCE_ON;
         reg_rdata             <= 8'h00;
         reg_rvalid            <= 1'b0;
      end
      else
      begin
         step_down_ctrl        <= next_step_down_ctrl;
         good_delays           <= next_good_delays;
         rail_disable_controls <= next_disable;
         rail_force_on_first   <= next_force_on;
         reg_rdata             <= next_rdata;
         reg_rvalid            <= next_rvalid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Three-stage synchroniser; a new level is taken only when stages two and
   // three agree, which filters a single metastable sample.
   always_comb
   begin
      next_stable = stable;
      for (int i = 0; i < SYNC_W; i++)
      begin
         if (sync2[i] == sync3[i])
            next_stable[i] = sync3[i];
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         sync1  <= '0;
         sync2  <= '0;
         sync3  <= '0;
         stable <= '0;
      end
      else
      begin
         sync1  <= {group_in_reg, rail_request};
         sync2  <= sync1;
         sync3  <= sync2;
         stable <= next_stable;
      end
   end

   assign req  = stable[NUM_RAILS-1:0];
   assign good = stable[SYNC_W-1:NUM_RAILS];

   ////////////////////////////////////////////////////////////////////////////
   // The shared-rail strap is caught once, on the first edge after reset
   // release, so a strap that wanders later cannot move the rail.
   always_comb
   begin
      next_shared_sel   = shared_sel;
      next_strap_caught = 1'b1;
      if (!strap_caught)
         next_shared_sel = shared_sel_strap;
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         shared_sel   <= 1'b0;
         strap_caught <= 1'b0;
      end
      else
      begin
         shared_sel   <= next_shared_sel;
         strap_caught <= next_strap_caught;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Delay timers, one per output pin. The code is turned into an exact cycle
   // count, so the timer runs two clocks past the coded delay, far inside the tolerance.
   assign code[PIN_ONE]  = {1'b0, good_delays[POS_ONE_DELAY +: 2]};
   assign code[PIN_TWO]  = good_delays[POS_TWO_DELAY +: 3];
   assign code[PIN_FOUR] = good_delays[POS_FOUR_DELAY +: 3];

   for (genvar p = 0; p < NUM_PINS; p++)
   begin : g_pin
      assign target[p] = CNT_W'(int'(DELAY_MS[code[p]]) * cycles_per_ms);

      good_delay_timer u_timer
      (
         .clk        (clk),
         .rstn       (rstn),
         .group_good (good[p]),
         .target     (target[p]),
         .done       (done[p])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Rail enables: request or force-on, gated by the disable bits. Pin two's
   // timed good still feeds the termination rail in software mode.
   always_comb
   begin
      force_vec = '0;
      force_vec[5:0] = rail_force_on_first[5:0];
      force_vec[RAIL_SWITCH_A_ONE] = rail_force_on_first[POS_SW_A_ONE_FORCE];
      force_vec[RAIL_REG_A_TWO]    = rail_force_on_first[POS_REG_A_TWO_FORCE];
      allow = '1;
      allow[2:0] = step_down_ctrl[2:0];
      allow[RAIL_SWITCH_A_ONE] = rail_disable_controls[POS_SWITCH_A_ONE];
      allow[RAIL_SWITCH_B_ONE] = rail_disable_controls[POS_SWITCH_B_ONE];
      allow[RAIL_TERMINATION]  = rail_disable_controls[POS_TERMINATION];
      if (shared_sel)
         allow[RAIL_LINEAR_A_ONE] = rail_disable_controls[POS_SHARED_OFF];
      else
         allow[RAIL_SWITCH_B_TWO] = rail_disable_controls[POS_SHARED_OFF];
      next_rail_enable = req | force_vec;
      next_rail_enable[RAIL_TERMINATION] = req[RAIL_TERMINATION]
                                         | (term_from_two & done[PIN_TWO]);
      next_rail_enable = next_rail_enable & allow;
      for (int i = 0; i < NUM_PINS; i++)
         next_pins[i] = pin_sw_mode[i] ? pin_sw_level[i] : done[i];
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         rail_enable <= '0;
         pins        <= '0;
      end
      else
      begin
         rail_enable <= next_rail_enable;
         pins        <= next_pins;
      end
   end

   assign output_pin_one  = pins[PIN_ONE];
   assign output_pin_two  = pins[PIN_TWO];
   assign output_pin_four = pins[PIN_FOUR];

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_b_one_off: assert property (
      !rail_disable_controls[POS_SWITCH_B_ONE] |=> !rail_enable[RAIL_SWITCH_B_ONE])
      else $error("switch B one on while disabled");

   a_a_one_off: assert property (
      !rail_disable_controls[POS_SWITCH_A_ONE] |=> !rail_enable[RAIL_SWITCH_A_ONE])
      else $error("switch A one on while disabled");

   a_term_off: assert property (
      !rail_disable_controls[POS_TERMINATION] |=> !rail_enable[RAIL_TERMINATION])
      else $error("termination on while disabled");

   a_shared_off: assert property (
      strap_caught && !rail_disable_controls[POS_SHARED_OFF]
      |=> !rail_enable[shared_sel ? RAIL_LINEAR_A_ONE : RAIL_SWITCH_B_TWO])
      else $error("shared rail on while disabled");

   a_step_down_off: assert property (
      !step_down_ctrl[0] |=> !rail_enable[RAIL_STEP_DOWN_ONE])
      else $error("step-down one on while disabled");

   a_force_a_two: assert property (
      rail_force_on_first[POS_REG_A_TWO_FORCE] |=> rail_enable[RAIL_REG_A_TWO])
      else $error("regulator A two not held on by force");

   a_force_step: assert property (
      rail_force_on_first[0] && step_down_ctrl[0] |=> rail_enable[RAIL_STEP_DOWN_ONE])
      else $error("step-down one not held on by force");

   a_pin_follow: assert property (
      !rail_force_on_first[1] && step_down_ctrl[1] |=> rail_enable[1] == $past(req[1]))
      else $error("step-down two does not follow its request");

   a_write_steers: assert property (
      reg_req.wr && reg_req.addr == ADDR_DISABLE && !reg_req.wdata[POS_SWITCH_B_ONE]
      |=> ##1 !rail_enable[RAIL_SWITCH_B_ONE])
      else $error("disable write did not reach the rail");

   a_code_max: assert property (
      code[PIN_TWO] == 3'h7 |-> target[PIN_TWO] == CNT_W'(100 * cycles_per_ms))
      else $error("pin two code seven is not 100 ms");

   a_code_four: assert property (
      code[PIN_FOUR] == 3'h6 |-> target[PIN_FOUR] == CNT_W'(75 * cycles_per_ms))
      else $error("pin four code six is not 75 ms");

   a_code_one: assert property (
      code[PIN_ONE] == 3'h3 |-> target[PIN_ONE] == CNT_W'(15 * cycles_per_ms))
      else $error("pin one code three is not 15 ms");

   a_sw_mode: assert property (
      pin_sw_mode[PIN_FOUR] |=> output_pin_four == $past(pin_sw_level[PIN_FOUR]))
      else $error("pin four ignores software level");

   a_pin_drop: assert property (
      !good[PIN_ONE] && !pin_sw_mode[PIN_ONE] |=> ##1 !output_pin_one)
      else $error("pin one high while group not in regulation");

endmodule : rail_enable_override

// ### hw/rail_ctrl_pkg.sv
package rail_ctrl_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets on the serial control bus.
   localparam logic [7:0] ADDR_STEP_DOWN_CTRL = 8'h9C;
   localparam logic [7:0] ADDR_GOOD_DELAYS    = 8'h9D;
   localparam logic [7:0] ADDR_DISABLE        = 8'h9F;
   localparam logic [7:0] ADDR_FORCE_ON       = 8'hA0;

   // Reset values; the real part takes them from factory configuration.
   localparam logic [7:0] RST_STEP_DOWN_CTRL  = 8'h07;
   localparam logic [7:0] RST_GOOD_DELAYS     = 8'h00;
   localparam logic [7:0] RST_DISABLE         = 8'hF0;
   localparam logic [7:0] RST_FORCE_ON        = 8'h00;

   // Writable bits of the step-down control register; bits 7:6 read zero.
   localparam logic [7:0] STEP_DOWN_CTRL_MASK = 8'h3F;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions.
   localparam int POS_TWO_DELAY       = 5;
   localparam int POS_FOUR_DELAY      = 2;
   localparam int POS_ONE_DELAY       = 0;
   localparam int POS_SHARED_OFF      = 7;
   localparam int POS_SWITCH_B_ONE    = 6;
   localparam int POS_SWITCH_A_ONE    = 5;
   localparam int POS_TERMINATION     = 4;
   localparam int POS_REG_A_TWO_FORCE = 7;
   localparam int POS_SW_A_ONE_FORCE  = 6;

   // Rail indices of the enable vector.
   localparam int NUM_RAILS           = 12;
   localparam int RAIL_STEP_DOWN_ONE  = 0;
   localparam int RAIL_SWITCH_A_ONE   = 6;
   localparam int RAIL_REG_A_TWO      = 7;
   localparam int RAIL_SWITCH_B_ONE   = 8;
   localparam int RAIL_SWITCH_B_TWO   = 9;
   localparam int RAIL_LINEAR_A_ONE   = 10;
   localparam int RAIL_TERMINATION    = 11;

   // Output pins handled here: index 0 is pin one, 1 is pin two, 2 is pin four.
   localparam int NUM_PINS            = 3;
   localparam int PIN_ONE             = 0;
   localparam int PIN_TWO             = 1;
   localparam int PIN_FOUR            = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Timing.
   localparam int CLK_PERIOD_NS       = 20;
   localparam int MS_IN_NS            = 1000000;
   localparam int CYC_PER_MS          = MS_IN_NS / CLK_PERIOD_NS;
   localparam int CNT_W               = 23;
   localparam logic [6:0] DELAY_MS [8] = '{7'h00, 7'h05, 7'h0A, 7'h0F,
                                           7'h14, 7'h32, 7'h4B, 7'h64};

   ////////////////////////////////////////////////////////////////////////////
   // Types.
   typedef struct packed
   {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   typedef enum logic [2:0]
   {
      T_IDLE  = 3'b001,
      T_COUNT = 3'b010,
      T_DONE  = 3'b100
   } timer_st_e;

endpackage : rail_ctrl_pkg

// ### hw/good_delay_timer.sv
module good_delay_timer
   import rail_ctrl_pkg::*;
(
   // Clock and reset.
   input  wire logic                         clk,
   input  wire logic                         rstn,
   // Group state and programmed delay in cycles.
   input  wire logic                         group_good,
   input  wire logic [rail_ctrl_pkg::CNT_W-1:0] target,
   // Delayed power-good.
   output logic                              done
);
   import rail_ctrl_pkg::*;

   timer_st_e          state;
   timer_st_e          next_state;
   logic [CNT_W-1:0]   count;
   logic [CNT_W-1:0]   next_count;

   ////////////////////////////////////////////////////////////////////////////
   // Counting only runs while the whole group is in regulation; any drop
   // restarts the delay from zero so a glitching rail never shortens it.
   always_comb
   begin
      next_state = state;
      next_count = count;
      case (state)
         T_IDLE:
         begin
            next_count = '0;
            if (group_good)
               next_state = T_COUNT;
         end
         T_COUNT:
         begin
            if (!group_good)
               next_state = T_IDLE;
            else if (count >= target)
               next_state = T_DONE;
            else
               next_count = count + 1'b1;
         end
         T_DONE:
         begin
            if (!group_good)
               next_state = T_IDLE;
         end
         default:
            next_state = T_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         state <= T_IDLE;
         count <= '0;
      end
      else
      begin
         state <= next_state;
         count <= next_count;
      end
   end

   assign done = (state == T_DONE);

   ////////////////////////////////////////////////////////////////////////////
   a_no_done_bad: assert property (@(posedge clk) disable iff (!rstn)
      !group_good |=> !done)
      else $error("delayed good high while group not in regulation");

   // A new delay written mid-count may drop below the running count for the
   // one edge at which it arrives; the timer then leaves counting at once.
   a_count_bound: assert property (@(posedge clk) disable iff (!rstn)
      (state == T_COUNT) && $stable(target) |-> (count <= target))
      else $error("delay counter passed its target");

endmodule : good_delay_timer

// ### testbench/host_bus.sv
module host_bus
   import rail_ctrl_pkg::*;
(
   // Clock.
   input  wire logic                    clk,
   // Register request and read answer.
   output rail_ctrl_pkg::reg_req_s      reg_req,
   input  wire logic [7:0]              reg_rdata,
   input  wire logic                    reg_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////
   // The bus starts idle so the first edge sees no strobe.
   initial reg_req = '0;

   // One byte write; gap idles first so slow hosts are covered too.
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input int gap = 0);
      logic [7:0] v;
      v = (a == ADDR_DISABLE) ? (d & 8'hF0) : d;
      repeat (gap) @(negedge clk);
      @(negedge clk);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(negedge clk);
      // Released lines show the inverse, so a stale byte is never reused.
      reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
   endtask : wr

   // One byte read; a missing answer comes back unknown and fails the compare.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk);
      reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
      d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
   endtask : rd

endmodule : host_bus

// ### testbench/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import rail_ctrl_pkg::*;

   ////////////////////////////////////////////////////////////
   // Milliseconds are shortened so the longest code takes 2000 cycles.
   localparam int CPM        = 20;
   localparam int MS_TAB [8] = '{0, 5, 10, 15, 20, 50, 75, 100};

   logic        clk;
   logic        rstn;
   reg_req_s    reg_req;
   logic [7:0]  reg_rdata;
   logic        reg_rvalid;
   logic [11:0] rail_request;
   logic [11:0] rail_enable;
   logic [2:0]  group_in_reg;
   logic [2:0]  pin_sw_mode;
   logic [2:0]  pin_sw_level;
   logic        shared_sel_strap;
   logic        term_from_two;
   logic        output_pin_one;
   logic        output_pin_two;
   logic        output_pin_four;
   int          fails = 0;
   int          total_checks = 0;
   int          cyc = 0;

   rail_enable_override #(.cycles_per_ms(CPM)) u_rail_enable_override
   (
      .clk(clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .rail_request(rail_request), .group_in_reg(group_in_reg),
      .shared_sel_strap(shared_sel_strap), .term_from_two(term_from_two),
      .pin_sw_mode(pin_sw_mode), .pin_sw_level(pin_sw_level), .rail_enable(rail_enable),
      .output_pin_one(output_pin_one), .output_pin_two(output_pin_two),
      .output_pin_four(output_pin_four)
   );

   host_bus u_host_bus
   (
      .clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
   );

   ////////////////////////////////////////////////////////////
   // Clock at 50 MHz.
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Cuts a hung run short; the tests need about 13000 cycles.
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         fails++;
         end_sim;
      end
   end

   task automatic end_sim;
      if (fails == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_sim

   // Compares any register byte, rail vector or pin level.
   task automatic chk_val(input logic [11:0] g, input logic [11:0] e, input string m);
      total_checks++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %0t %s: got %h, expected %h", $time, m, g, e);
      end
   endtask : chk_val

   // Compares a measured delay in cycles with its allowed window.
   task automatic chk_range(input int n, input int lo, input int hi);
      total_checks++;
      if (n < lo || n > hi)
      begin
         fails++;
         $display("[ERR] %0t delay %0d cycles, allowed %0d to %0d", $time, n, lo, hi);
      end
   endtask : chk_range

   function automatic logic ob(input int s);
      logic [3:0] v;
      v = {rail_enable[RAIL_TERMINATION], output_pin_four, output_pin_two, output_pin_one};
      return v[s];
   endfunction : ob

   ////////////////////////////////////////////////////////////
   // Asynchronous inputs need about five edges to reach the logic.
   task automatic settle;
      repeat (8) @(negedge clk);
   endtask : settle

   task automatic do_reset(input logic s);
      @(negedge clk);
      rstn = 1'b0;
      shared_sel_strap = s;
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      repeat (2) @(negedge clk);
   endtask : do_reset

   // A register write must steer the rails one edge after it is taken.
   task automatic wr_rail(input logic [7:0] a, input logic [7:0] d, input logic [11:0] e);
      u_host_bus.wr(a, d);
      @(negedge clk);
      chk_val(rail_enable, e, "rail enables after write");
   endtask : wr_rail

   // Raises one group and times the observed output, then drops the group.
   task automatic meas(input int sel, input int grp, input int ms);
      int n;
      n = 0;
      group_in_reg[grp] = 1'b1;
      while (ob(sel) !== 1'b1 && n < 2400)
      begin
         @(negedge clk);
         n++;
      end
      chk_range(n, ms * CPM * 9 / 10, ms * CPM * 11 / 10 + 10);
      group_in_reg[grp] = 1'b0;
      settle;
      chk_val(12'(ob(sel)), 12'h000, "output after group drop");
   endtask : meas

   task automatic t_reset;
      logic [7:0] d;
      logic [7:0] a [5];
      logic [7:0] v [5];
      a = '{ADDR_STEP_DOWN_CTRL, ADDR_GOOD_DELAYS, ADDR_DISABLE, ADDR_FORCE_ON, 8'h9E};
      v = '{RST_STEP_DOWN_CTRL, RST_GOOD_DELAYS, RST_DISABLE, RST_FORCE_ON, 8'h00};
      for (int i = 0; i < 5; i++)
      begin
         u_host_bus.rd(a[i], d);
         chk_val(12'(d), 12'(v[i]), "value after reset");
      end
   endtask : t_reset

   task automatic t_regs;
      logic [7:0] d;
      u_host_bus.wr(ADDR_STEP_DOWN_CTRL, 8'hFF);
      u_host_bus.rd(ADDR_STEP_DOWN_CTRL, d);
      chk_val(12'(d), 12'h03F, "step-down control readback");
      u_host_bus.wr(8'h9E, 8'h55, 3);
      u_host_bus.rd(8'h9E, d);
      chk_val(12'(d), 12'h000, "unmapped readback");
      u_host_bus.wr(ADDR_GOOD_DELAYS, 8'hA5);
      u_host_bus.rd(ADDR_GOOD_DELAYS, d);
      chk_val(12'(d), 12'h0A5, "delay readback");
      u_host_bus.wr(ADDR_DISABLE, 8'hFF);
      u_host_bus.rd(ADDR_DISABLE, d);
      chk_val(12'(d), 12'h0F0, "disable readback");
      u_host_bus.wr(ADDR_STEP_DOWN_CTRL, 8'h07);
   endtask : t_regs

   task automatic t_force;
      wr_rail(ADDR_FORCE_ON, 8'hFF, 12'h0FF);
      wr_rail(ADDR_DISABLE, 8'h00, 12'h0BF);
      wr_rail(ADDR_STEP_DOWN_CTRL, 8'h38, 12'h0B8);
      wr_rail(ADDR_STEP_DOWN_CTRL, 8'h07, 12'h0BF);
      wr_rail(ADDR_DISABLE, 8'hF0, 12'h0FF);
      wr_rail(ADDR_FORCE_ON, 8'h00, 12'h000);
   endtask : t_force

   task automatic t_request;
      rail_request = 12'hFFF;
      settle;
      chk_val(rail_enable, 12'hFFF, "requested rails");
      wr_rail(ADDR_DISABLE, 8'h00, 12'h4BF);
      wr_rail(ADDR_STEP_DOWN_CTRL, 8'h38, 12'h4B8);
      wr_rail(ADDR_STEP_DOWN_CTRL, 8'h07, 12'h4BF);
      wr_rail(ADDR_DISABLE, 8'hF0, 12'hFFF);
      rail_request = 12'h000;
      settle;
      chk_val(rail_enable, 12'h000, "released rails");
   endtask : t_request

   // The other strap setting hands disable bit 7 to the linear regulator.
   task automatic t_shared;
      do_reset(1'b1);
      rail_request = 12'hFFF;
      settle;
      wr_rail(ADDR_DISABLE, 8'h70, 12'hBFF);
      wr_rail(ADDR_DISABLE, 8'hF0, 12'hFFF);
      rail_request = 12'h000;
      do_reset(1'b0);
   endtask : t_shared

   task automatic t_delays(input int sel, input int pos, input int nc);
      for (int c = 0; c < nc; c++)
      begin
         u_host_bus.wr(ADDR_GOOD_DELAYS, 8'(c << pos));
         meas(sel, sel, MS_TAB[c]);
      end
   endtask : t_delays

   // A group that drops out mid-count must start its delay again.
   task automatic t_restart;
      u_host_bus.wr(ADDR_GOOD_DELAYS, 8'h08);
      group_in_reg[PIN_FOUR] = 1'b1;
      repeat (150) @(negedge clk);
      group_in_reg[PIN_FOUR] = 1'b0;
      settle;
      chk_val(12'(output_pin_four), 12'h000, "pin four before delay");
      meas(PIN_FOUR, PIN_FOUR, 10);
   endtask : t_restart

   task automatic t_sw;
      u_host_bus.wr(ADDR_GOOD_DELAYS, 8'hFF);
      pin_sw_mode = 3'b111;
      group_in_reg = 3'b111;
      settle;
      for (int p = 0; p < 3; p++)
      begin
         pin_sw_level[p] = 1'b1;
         repeat (2) @(negedge clk);
         chk_val(12'(ob(p)), 12'h001, "software level high");
         pin_sw_level[p] = 1'b0;
         repeat (2) @(negedge clk);
         chk_val(12'(ob(p)), 12'h000, "software level low");
      end
      group_in_reg = 3'b000;
      pin_sw_mode = 3'b010;
      term_from_two = 1'b1;
      u_host_bus.wr(ADDR_GOOD_DELAYS, 8'h20);
      settle;
      meas(3, PIN_TWO, 5);
      group_in_reg[PIN_TWO] = 1'b1;
      repeat (120) @(negedge clk);
      chk_val(12'(output_pin_two), 12'h000, "pin two under software");
      group_in_reg[PIN_TWO] = 1'b0;
      settle;
      term_from_two = 1'b0;
      pin_sw_mode = 3'b000;
   endtask : t_sw

   ////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      rstn = 1'b0;
      shared_sel_strap = 1'b0;
      term_from_two = 1'b0;
      pin_sw_mode = 3'b000;
      pin_sw_level = 3'b000;
      rail_request = 12'h000;
      group_in_reg = 3'b000;
      do_reset(1'b0);
      t_reset;
      t_regs;
      t_force;
      t_request;
      t_shared;
      t_delays(PIN_TWO, 5, 8);
      t_delays(PIN_FOUR, 2, 8);
      t_delays(PIN_ONE, 0, 4);
      t_restart;
      t_sw;
      end_sim;
   end

endmodule : testbench
